// ==== shared/pause_cfg_pkg.sv ====
// constants for the port 1 pause and backpressure configuration block
// Operation
// - backpressure is only generated on port 1 while bit 6 holds 1.
// - read-only bit 5 shows the duplex in effect, 0 full and 1 half.
// - read-only bit 4 shows whether receive pause is currently enabled.
// - read-only bit 3 shows whether transmit pause is currently enabled.
// - bit 2 enables receive pause detection when manual or negotiation off.
// - bit 1 enables pause generation when manual or negotiation off.
// - manual clear with negotiation on takes pause from the negotiation.
// - manual clear with negotiation off applies the programmed bits.
// - manual set makes the programmed bits rule in full duplex.
// - status bits read back the settings in force, whatever their source.
// - writes never touch the phy advertisement pause abilities.
// - bits 6, 2, 1 and 0 take their defaults from straps caught after reset release.
// - a loader rewrite of the straps updates those fields.
`default_nettype none
package pause_cfg_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] PORT1_FLOW_CONTROL_OFFSET = 12'h1A0;
	localparam int DECODE_MSB = 11;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BACKPRESSURE_BIT = 6;
	localparam int CUR_DUPLEX_BIT = 5;
	localparam int CUR_RX_PAUSE_BIT = 4;
	localparam int CUR_TX_PAUSE_BIT = 3;
	localparam int RX_PAUSE_BIT = 2;
	localparam int TX_PAUSE_BIT = 1;
	localparam int MANUAL_SELECT_BIT = 0;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic CFG_BIT_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// power-up sequence of the strap capture
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_CAPTURE,
		ST_RUN
	} start_state_e;

endpackage
`default_nettype wire

// ==== verilog/sync2.sv ====
// two flip-flop synchroniser for pin-level inputs
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// level from outside the clock domain
	input wire logic [WIDTH-1:0] async_in,
	// synchronised level
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;

	// first stage is read only by the second
	always_comb begin
		meta_d = async_in;
		stable_d = meta_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			stable_q <= '0;
		end else begin
			meta_q <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign sync_out = stable_q;

endmodule
`default_nettype wire

// ==== verilog/flow_resolve.sv ====
// resolution of the pause and duplex settings in force on port 1
`default_nettype none
module flow_resolve (
	// programmed settings
	input wire logic manual_select,
	input wire logic rx_pause_bit,
	input wire logic tx_pause_bit,
	// link state from the phy
	input wire logic an_enable,
	input wire logic link_half_duplex,
	input wire logic an_rx_pause,
	input wire logic an_tx_pause,
	// resolved result
	output logic cur_half_duplex,
	output logic cur_rx_pause,
	output logic cur_tx_pause
);

	logic use_programmed;

	// pause frames only mean something in full duplex
	always_comb begin
		use_programmed = manual_select || !an_enable;
		cur_half_duplex = link_half_duplex;
		if (link_half_duplex) begin
			cur_rx_pause = 1'b0;
			cur_tx_pause = 1'b0;
		end else if (use_programmed) begin
			cur_rx_pause = rx_pause_bit;
			cur_tx_pause = tx_pause_bit;
		end else begin
			cur_rx_pause = an_rx_pause;
			cur_tx_pause = an_tx_pause;
		end
	end

endmodule
`default_nettype wire

// ==== verilog/port_pause_flow_config.sv ====
// port 1 pause and backpressure configuration register on ahb-lite
//
// Our own choice: the AHB-Lite register port.
`default_nettype none
module port_pause_flow_config
	import pause_cfg_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,

	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,

	// configuration strap pins
	input wire logic port1_backpressure_strap,
	input wire logic port1_full_duplex_pause_strap,
	input wire logic port1_manual_select_strap,

	// strap rewrite from the eeprom loader, same clock
	input wire logic loader_strap_write,
	input wire logic loader_backpressure,
	input wire logic loader_full_duplex_pause,
	input wire logic loader_manual_select,

	// phy link state pins
	input wire logic phy_an_enable,
	input wire logic phy_link_half_duplex,
	input wire logic phy_an_rx_pause,
	input wire logic phy_an_tx_pause,

	// controls to the port 1 mac
	output logic port1_backpressure_active,
	output logic port1_rx_pause_active,
	output logic port1_tx_pause_active,
	output logic port1_half_duplex
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] strap_sync;
	logic [3:0] phy_sync;
	logic strap_bp;
	logic strap_fd_pause;
	logic strap_manual;
	logic an_enable;
	logic link_half;
	logic an_rx;
	logic an_tx;

	sync2 #(
		.WIDTH(3)
	) u_strap_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({port1_backpressure_strap, port1_full_duplex_pause_strap,
			port1_manual_select_strap}),
		.sync_out(strap_sync)
	);

	sync2 #(
		.WIDTH(4)
	) u_phy_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({phy_an_enable, phy_link_half_duplex, phy_an_rx_pause,
			phy_an_tx_pause}),
		.sync_out(phy_sync)
	);

	assign strap_bp = strap_sync[2];
	assign strap_fd_pause = strap_sync[1];
	assign strap_manual = strap_sync[0];
	assign an_enable = phy_sync[3];
	assign link_half = phy_sync[2];
	assign an_rx = phy_sync[1];
	assign an_tx = phy_sync[0];

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	start_state_e start_q;
	start_state_e start_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic strap_capture;

	// straps are pins, so they are taken once the synchroniser is filled
	always_comb begin
		start_d = start_q;
		settle_d = settle_q;
		strap_capture = 1'b0;
		case (start_q)
			ST_SETTLE: begin
				settle_d = settle_q + 2'h1;
				if (settle_q == STRAP_SETTLE_CYCLES) begin
					start_d = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				strap_capture = 1'b1;
				start_d = ST_RUN;
			end
			ST_RUN: begin
				start_d = ST_RUN;
			end
			default: begin
				start_d = ST_SETTLE;
				settle_d = '0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= ST_SETTLE;
			settle_q <= '0;
		end else begin
			start_q <= start_d;
			settle_q <= settle_d;
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite address phase capture
	// ----------------------------------------------------------------
	logic wr_pend_q;
	logic wr_pend_d;
	logic hit_q;
	logic hit_d;
	logic addr_phase;
	logic addr_hit;

	// only nonseq and seq start a transfer; idle and busy are ignored
	always_comb begin
		addr_phase = hsel && htrans[1] && hready;
		addr_hit = haddr[DECODE_MSB:0] == PORT1_FLOW_CONTROL_OFFSET;
		wr_pend_d = addr_phase && hwrite;
		hit_d = addr_phase && addr_hit;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			hit_q <= hit_d;
		end
	end

	// ----------------------------------------------------------------
	// writable fields
	// ----------------------------------------------------------------
	logic bp_en_q;
	logic bp_en_d;
	logic rx_en_q;
	logic rx_en_d;
	logic tx_en_q;
	logic tx_en_d;
	logic manual_q;
	logic manual_d;
	logic sw_write;

	// loader beats software in the same cycle: straps are the newer truth
	always_comb begin
		sw_write = wr_pend_q && hit_q;
		bp_en_d = bp_en_q;
		rx_en_d = rx_en_q;
		tx_en_d = tx_en_q;
		manual_d = manual_q;
		if (strap_capture) begin
			bp_en_d = strap_bp;
			rx_en_d = strap_fd_pause;
			tx_en_d = strap_fd_pause;
			manual_d = strap_manual;
		end else if (loader_strap_write) begin
			bp_en_d = loader_backpressure;
			rx_en_d = loader_full_duplex_pause;
			tx_en_d = loader_full_duplex_pause;
			manual_d = loader_manual_select;
		end else if (sw_write) begin
			// status and reserved bits are dropped here
			bp_en_d = hwdata[BACKPRESSURE_BIT];
			rx_en_d = hwdata[RX_PAUSE_BIT];
			tx_en_d = hwdata[TX_PAUSE_BIT];
			manual_d = hwdata[MANUAL_SELECT_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bp_en_q <= CFG_BIT_RESET;
			rx_en_q <= CFG_BIT_RESET;
			tx_en_q <= CFG_BIT_RESET;
			manual_q <= CFG_BIT_RESET;
		end else begin
			bp_en_q <= bp_en_d;
			rx_en_q <= rx_en_d;
			tx_en_q <= tx_en_d;
			manual_q <= manual_d;
		end
	end

	// ----------------------------------------------------------------
	// resolution of the settings in force
	// ----------------------------------------------------------------
	logic cur_half;
	logic cur_rx;
	logic cur_tx;
	logic nxt_half;
	logic nxt_rx;
	logic nxt_tx;

	// the phy advertisement is not an output here, so writes cannot reach it
	flow_resolve u_resolve_now (
		.manual_select(manual_q),
		.rx_pause_bit(rx_en_q),
		.tx_pause_bit(tx_en_q),
		.an_enable(an_enable),
		.link_half_duplex(link_half),
		.an_rx_pause(an_rx),
		.an_tx_pause(an_tx),
		.cur_half_duplex(cur_half),
		.cur_rx_pause(cur_rx),
		.cur_tx_pause(cur_tx)
	);

	// second copy on next values lets a read see a write just before it
	flow_resolve u_resolve_next (
		.manual_select(manual_d),
		.rx_pause_bit(rx_en_d),
		.tx_pause_bit(tx_en_d),
		.an_enable(an_enable),
		.link_half_duplex(link_half),
		.an_rx_pause(an_rx),
		.an_tx_pause(an_tx),
		.cur_half_duplex(nxt_half),
		.cur_rx_pause(nxt_rx),
		.cur_tx_pause(nxt_tx)
	);

	// ----------------------------------------------------------------
	// mac controls
	// ----------------------------------------------------------------
	logic bp_act_q;
	logic bp_act_d;
	logic rx_act_q;
	logic rx_act_d;
	logic tx_act_q;
	logic tx_act_d;
	logic half_q;
	logic half_d;

	// backpressure is a half duplex mechanism only
	always_comb begin
		bp_act_d = bp_en_q && cur_half;
		rx_act_d = cur_rx;
		tx_act_d = cur_tx;
		half_d = cur_half;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bp_act_q <= 1'b0;
			rx_act_q <= 1'b0;
			tx_act_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			bp_act_q <= bp_act_d;
			rx_act_q <= rx_act_d;
			tx_act_q <= tx_act_d;
			half_q <= half_d;
		end
	end

	assign port1_backpressure_active = bp_act_q;
	assign port1_rx_pause_active = rx_act_q;
	assign port1_tx_pause_active = tx_act_q;
	assign port1_half_duplex = half_q;

	// ----------------------------------------------------------------
	// read data and response
	// ----------------------------------------------------------------
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic ready_q;
	logic resp_q;

	// read data is built in the address phase so every transfer is zero wait
	always_comb begin
		rdata_d = RDATA_RESET;
		if (addr_phase && addr_hit && !hwrite) begin
			rdata_d[BACKPRESSURE_BIT] = bp_en_d;
			rdata_d[CUR_DUPLEX_BIT] = nxt_half;
			rdata_d[CUR_RX_PAUSE_BIT] = nxt_rx;
			rdata_d[CUR_TX_PAUSE_BIT] = nxt_tx;
			rdata_d[RX_PAUSE_BIT] = rx_en_d;
			rdata_d[TX_PAUSE_BIT] = tx_en_d;
			rdata_d[MANUAL_SELECT_BIT] = manual_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= RDATA_RESET;
			ready_q <= 1'b0;
			resp_q <= HRESP_OKAY;
		end else begin
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
			resp_q <= HRESP_OKAY;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = ready_q;
	assign hresp = resp_q;

endmodule
`default_nettype wire

// ==== dv/port_pause_flow_props.sv ====
// concurrent checks on the port 1 pause configuration block
`default_nettype none
module port_pause_flow_props
	import pause_cfg_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// link and mac side
	input wire logic phy_link_half_duplex,
	input wire logic port1_backpressure_active,
	input wire logic port1_rx_pause_active,
	input wire logic port1_tx_pause_active,
	input wire logic port1_half_duplex
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// read taken this edge, and whether it hits the register
	logic rd_take;
	logic hit;
	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	assign hit = haddr[11:0] == PORT1_FLOW_CONTROL_OFFSET;

	bp_gate_a: assert property (
		port1_backpressure_active |-> port1_half_duplex)
		else $error("backpressure while full duplex");
	half_no_pause_a: assert property (
		port1_half_duplex |-> !port1_rx_pause_active && !port1_tx_pause_active)
		else $error("pause active in half duplex");
	rsvd_zero_a: assert property (hrdata[31:7] == 25'h0)
		else $error("reserved read bits not zero");
	rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
		else $error("read data outside a read");
	miss_zero_a: assert property (rd_take && !hit |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	duplex_follow_a: assert property (
		$stable(phy_link_half_duplex) [*5] |->
		port1_half_duplex == phy_link_half_duplex)
		else $error("duplex output does not follow link");
	duplex_read_a: assert property (
		$stable(phy_link_half_duplex) [*5] ##0 rd_take && hit |=>
		hrdata[5] == $past(phy_link_half_duplex))
		else $error("duplex status bit wrong");
	ready_high_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("wait state inserted");
	hresp_okay_a: assert property (hresp == HRESP_OKAY)
		else $error("error response");
endmodule

bind port_pause_flow_config port_pause_flow_props port_pause_flow_props_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp),
	.phy_link_half_duplex(phy_link_half_duplex),
	.port1_backpressure_active(port1_backpressure_active),
	.port1_rx_pause_active(port1_rx_pause_active),
	.port1_tx_pause_active(port1_tx_pause_active),
	.port1_half_duplex(port1_half_duplex)
);
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the port 1 pause configuration block
`default_nettype none
module tb
	import pause_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic bp_s, fd_s, man_s, ld_w, ld_bp, ld_fd, ld_man;
	logic an_en, half, an_rx, an_tx, bp_o, rx_o, tx_o, half_o;
	int n_fail = 0;
	int checks_done = 0;
	assign hready = hreadyout;
	port_pause_flow_config port_pause_flow_config_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .port1_backpressure_strap(bp_s),
		.port1_full_duplex_pause_strap(fd_s),
		.port1_manual_select_strap(man_s), .loader_strap_write(ld_w),
		.loader_backpressure(ld_bp), .loader_full_duplex_pause(ld_fd),
		.loader_manual_select(ld_man), .phy_an_enable(an_en),
		.phy_link_half_duplex(half), .phy_an_rx_pause(an_rx),
		.phy_an_tx_pause(an_tx), .port1_backpressure_active(bp_o),
		.port1_rx_pause_active(rx_o), .port1_tx_pause_active(tx_o),
		.port1_half_duplex(half_o)
	);
	// compare with case equality so unknowns never match
	`define CHK(got, exp) begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
		end \
	end
	// 4 ns clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// ----------------------------------------------------------------
	// bus tasks, entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// one transfer; bounded waits on hready since no latency is assumed
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		rd = hrdata;
		if (n >= 40) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic wr(input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, 32'h0000_01A0, d, x);
	endtask
	task automatic rd_exp(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		`CHK(d, e)
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// straps bp and fd set, negotiation gives tx pause only
	task automatic t_defaults();
		rd_exp(32'h0000_01A0, 32'h0000_004E);
	endtask
	// programmed bits ignored while negotiation rules
	task automatic t_autoneg();
		wr(32'h0000_0000);
		rd_exp(32'h0000_01A0, 32'h0000_0008);
	endtask
	// manual select: programmed tx only, in full duplex
	task automatic t_manual();
		wr(32'h0000_0003);
		rd_exp(32'h0000_01A0, 32'h0000_000B);
		cyc(2);
		`CHK({rx_o, tx_o}, 2'b01)
	endtask
	// negotiation off: programmed rx applies without manual select
	task automatic t_an_off();
		an_en <= 1'b0;
		wr(32'h0000_0004);
		cyc(4);
		rd_exp(32'h0000_01A0, 32'h0000_0014);
		`CHK({rx_o, tx_o}, 2'b10)
	endtask
	// reserved and status bits drop writes; neighbour offset unmapped
	task automatic t_reserved();
		wr(32'hFFFF_FFFF);
		rd_exp(32'h0000_01A0, 32'h0000_005F);
		rd_exp(32'h0000_01A4, 32'h0000_0000);
	endtask
	// half duplex: pause forced off, backpressure follows bit 6
	task automatic t_half();
		half <= 1'b1;
		cyc(5);
		rd_exp(32'h0000_01A0, 32'h0000_0067);
		`CHK({bp_o, rx_o, tx_o, half_o}, 4'b1001)
		wr(32'h0000_0007);
		cyc(3);
		`CHK(bp_o, 1'b0)
		rd_exp(32'h0000_01A0, 32'h0000_0027);
	endtask
	// loader rewrites straps, fields take the new values
	task automatic t_loader();
		ld_w <= 1'b1;
		ld_bp <= 1'b1;
		ld_fd <= 1'b0;
		ld_man <= 1'b0;
		cyc(1);
		ld_w <= 1'b0;
		cyc(1);
		rd_exp(32'h0000_01A0, 32'h0000_0060);
		cyc(2);
		`CHK(bp_o, 1'b1)
	endtask
	// counts, verdict and end of run
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{bp_s, fd_s, man_s} = 3'b110;
		{ld_w, ld_bp, ld_fd, ld_man} = 4'h0;
		{an_en, half, an_rx, an_tx} = 4'b1001;
		cyc(4);
		hresetn <= 1'b1;
		cyc(6);
		t_defaults();
		t_autoneg();
		t_manual();
		t_an_off();
		t_reserved();
		t_half();
		t_loader();
		conclude();
	end
endmodule
`default_nettype wire
